// ### hdl/addr_map.sv
// Pointer to page, word and byte fields, boot size decode, section check.
// Purely combinational; the caller registers what it keeps.
module addr_map (
   // Inputs
   input wire logic [15:0] pointer_i,
   input wire logic [1:0] boot_size_i,
   // Outputs
   output logic [7:0] page_o,
   output logic [5:0] word_o,
   output logic byte_sel_o,
   output logic [13:0] word_addr_o,
   output logic in_halting_o,
   output logic [13:0] boot_start_o
);
   function automatic logic [13:0] boot_start(input logic [1:0] sz);
      case (sz)
         2'b11: boot_start = spm_pkg::BOOT_START_256;
         2'b10: boot_start = spm_pkg::BOOT_START_512;
         2'b01: boot_start = spm_pkg::BOOT_START_1K;
         default: boot_start = spm_pkg::BOOT_START_2K;
      endcase
   endfunction

   // R12: page and word fields; R14: top pointer bit unused
   assign page_o = pointer_i[14:7];
   assign word_o = pointer_i[6:1];
   assign byte_sel_o = pointer_i[0];
   assign word_addr_o = pointer_i[14:1];
   // R11: halting section is the top pages, whatever the boot size
   assign in_halting_o = (pointer_i[14:7] >= spm_pkg::HALT_FIRST_PAGE);
   // R10: boot size selects boot start word
   assign boot_start_o = boot_start(boot_size_i);
endmodule // addr_map

// ### hdl/op_timer.sv
// Programming duration timer for erase, write and lock-bit operations.
// Assumes start_i is a one-cycle pulse; only the power-on reset stops it.
module op_timer #(
   parameter int TICK_CYCLES = spm_pkg::TICK_CYCLES,
   parameter int PROG_TICKS = spm_pkg::PROG_TICKS
)(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Control
   input wire logic start_i,
   output logic busy_o,
   output logic done_o
);
   localparam int TOTAL = TICK_CYCLES * PROG_TICKS;
   if (TICK_CYCLES < 1 || PROG_TICKS < 1) begin : g_check
      $error("op_timer: counts must be at least one");
   end
   logic [$clog2(TICK_CYCLES+1)-1:0] pre_reg;
   logic [$clog2(PROG_TICKS+1)-1:0] tick_reg;
   logic [31:0] run_cnt;
   logic pre_last;
   logic tick_last;
   assign pre_last = (32'(pre_reg) == TICK_CYCLES - 1);
   assign tick_last = (32'(tick_reg) == PROG_TICKS - 1);

   // R9: fixed programming time
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         pre_reg <= '0;
         tick_reg <= '0;
      end else begin
         done_o <= busy_o & pre_last & tick_last;
         if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            pre_reg <= '0;
            tick_reg <= '0;
         end else if (busy_o) begin
            if (pre_last) begin
               pre_reg <= '0;
               if (tick_last) begin
                  busy_o <= 1'b0;
               end else begin
                  tick_reg <= tick_reg + 1'b1;
               end
            end else begin
               pre_reg <= pre_reg + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_cnt <= '0;
      end else if (start_i && !busy_o) begin
         run_cnt <= '0;
      end else if (busy_o) begin
         run_cnt <= run_cnt + 32'h1;
      end
   end

   a_prog_duration: assert property ( // R9
      @(posedge clock_i) disable iff (!rst_n_i)
      done_o |-> (run_cnt == TOTAL))
      else $error("programming time not exact");
endmodule // op_timer

// ### hdl/self_program_fuse_lock_readback.sv
// Self-programming sequencer: control register, timed windows, fuse and
// lock readback, page operations. Assumes the core, fuse cells and flash
// array all run on clock_i and that strobes are one cycle long.
//
// How it works
// R1: pointer 0001 in window returns lock byte
// R2: enable bits clear on read, expiry
// R3: outside window, load reads flash byte
// R4: lock byte layout, top two undefined
// R5: pointer 0000 in window returns low fuses
// R6: pointer 0003 in window returns high fuses
// R7: programmed bits read zero, others one
// R8: running write survives a core reset
// R9: erase, write, lock take fixed time
// R10: boot size picks boot start word
// R11: fixed halting and concurrent sections
// R12: pointer maps to page and word
// R13: software zeroes word field on write
// R14: top pointer bit ignored, bit0 selects byte
// R15: only halting section runs during ops
// R16: busy flag holds until re-enable
// R17: software waits for EEPROM write first
// R18: windows counted after register write
module self_program_fuse_lock_readback #(
   parameter int TICK_CYCLES = spm_pkg::TICK_CYCLES,
   parameter int PROG_TICKS = spm_pkg::PROG_TICKS
)(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic sys_reset_i,
   // Register port
   input wire logic [5:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Core instruction strobes
   input wire logic [15:0] pointer_i,
   input wire logic load_req_i,
   input wire logic store_req_i,
   input wire logic [15:0] store_data_i,
   input wire logic eeprom_write_busy_i,
   output logic load_valid_o,
   output logic [7:0] load_data_o,
   // Fuse and lock cells, a one means programmed
   input wire logic [7:0] low_fuse_prog_i,
   input wire logic [7:0] high_fuse_prog_i,
   input wire logic [5:0] lock_prog_i,
   output logic lock_wr_o,
   output logic [3:0] lock_wr_data_o,
   // Flash array
   output logic flash_rd_o,
   output logic [13:0] flash_word_addr_o,
   input wire logic [15:0] flash_rdata_i,
   output spm_pkg::flash_op_t flash_op_o,
   output logic buf_load_o,
   output logic [5:0] buf_word_o,
   output logic [15:0] buf_data_o,
   output logic buf_clear_o,
   // Core control
   output logic cpu_halt_o,
   output logic rww_block_o,
   output logic [13:0] boot_start_o
);
   // ****************************************
   // Declarations
   // ****************************************
   spm_pkg::seq_state_t state_reg;
   spm_pkg::seq_state_t state_next;
   logic [2:0] win_reg;
   logic [4:0] ctrl_reg;
   logic busy_flag_reg;
   logic op_lock_reg;
   logic pend_flash_reg;
   logic pend_fuse_reg;
   logic byte_sel_reg;
   logic [7:0] fuse_data_reg;
   logic [7:0] page;
   logic [5:0] word;
   logic byte_sel;
   logic [13:0] word_addr;
   logic in_halting;
   logic [13:0] boot_start;
   logic [7:0] low_fuse_rd;
   logic [7:0] high_fuse_rd;
   logic [7:0] lock_rd;
   logic ctrl_wr;
   logic armed;
   logic read_mode;
   logic fuse_load;
   logic store_go;
   logic start_op;
   logic reen_go;
   logic timer_busy;
   logic timer_done;
   logic [7:0] ctrl_view;

   // ****************************************
   // Readback values
   // ****************************************
   // R7: programmed cells read as zero
   assign low_fuse_rd = ~low_fuse_prog_i;
   assign high_fuse_rd = ~high_fuse_prog_i;
   // R4: undefined top bits read as one
   assign lock_rd = {2'b11, ~lock_prog_i};

   addr_map u_map (
      .pointer_i(pointer_i),
      .boot_size_i(high_fuse_rd[spm_pkg::BOOT_SZ_POS+1:spm_pkg::BOOT_SZ_POS]),
      .page_o(page),
      .word_o(word),
      .byte_sel_o(byte_sel),
      .word_addr_o(word_addr),
      .in_halting_o(in_halting),
      .boot_start_o(boot_start)
   );

   op_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .PROG_TICKS(PROG_TICKS)
   ) u_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(start_op),
      .busy_o(timer_busy),
      .done_o(timer_done)
   );

   // ****************************************
   // Sequencer
   // ****************************************
   // R17: an EEPROM write in progress locks out the control register
   assign ctrl_wr = reg_wr_i && (reg_addr_i == spm_pkg::CTRL_ADDR) &&
                    !eeprom_write_busy_i && (state_reg == spm_pkg::ST_IDLE);
   assign armed = (state_reg == spm_pkg::ST_ARMED);
   assign read_mode = armed && ctrl_reg[spm_pkg::LOCK_BIT];
   assign fuse_load = read_mode && load_req_i;
   assign store_go = armed && store_req_i && !fuse_load;
   assign start_op = store_go && (ctrl_reg[spm_pkg::ERASE_BIT] ||
                     ctrl_reg[spm_pkg::WRITE_BIT] ||
                     ctrl_reg[spm_pkg::LOCK_BIT]);
   assign reen_go = store_go && !start_op && ctrl_reg[spm_pkg::REEN_BIT];

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         spm_pkg::ST_IDLE: begin
            if (ctrl_wr && reg_wdata_i[spm_pkg::EN_BIT]) begin
               state_next = spm_pkg::ST_ARMED;
            end
         end
         spm_pkg::ST_ARMED: begin
            // R2: clear on completed read, taken store or expiry
            if (start_op) begin
               state_next = spm_pkg::ST_RUN;
            end else if (store_go || fuse_load || win_reg == 3'h1 ||
                         sys_reset_i) begin
               state_next = spm_pkg::ST_IDLE;
            end
         end
         spm_pkg::ST_RUN: begin
            // R8: a core reset does not cut the operation short
            if (timer_done) begin
               state_next = spm_pkg::ST_IDLE;
            end
         end
         default: state_next = spm_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= spm_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // R18: window counts from the cycle after the write
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_reg <= 3'h0;
      end else if (ctrl_wr && reg_wdata_i[spm_pkg::EN_BIT]) begin
         win_reg <= reg_wdata_i[spm_pkg::LOCK_BIT] ? spm_pkg::LOAD_WIN :
                    spm_pkg::STORE_WIN;
      end else if (win_reg != 3'h0) begin
         win_reg <= win_reg - 3'h1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= spm_pkg::CTRL_RESET[4:0];
      end else if (ctrl_wr) begin
         ctrl_reg <= reg_wdata_i[4:0];
      end else if (state_next == spm_pkg::ST_IDLE) begin
         ctrl_reg <= 5'h00;
      end
   end

   // R16: busy set by a page operation, cleared only by re-enable
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_flag_reg <= 1'b0;
      end else if (start_op && !ctrl_reg[spm_pkg::LOCK_BIT]) begin
         busy_flag_reg <= 1'b1;
      end else if (reen_go) begin
         busy_flag_reg <= 1'b0;
      end
   end

   // ****************************************
   // Page operations
   // ****************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flash_op_o <= '0;
         lock_wr_o <= 1'b0;
         lock_wr_data_o <= 4'hF;
         op_lock_reg <= 1'b0;
         cpu_halt_o <= 1'b0;
         rww_block_o <= 1'b0;
      end else begin
         // R13: the word field is left out of the page address
         flash_op_o.erase <= start_op && ctrl_reg[spm_pkg::ERASE_BIT];
         flash_op_o.write <= start_op && ctrl_reg[spm_pkg::WRITE_BIT] &&
                             !ctrl_reg[spm_pkg::ERASE_BIT];
         lock_wr_o <= start_op && ctrl_reg[spm_pkg::LOCK_BIT] &&
                      !ctrl_reg[spm_pkg::ERASE_BIT] &&
                      !ctrl_reg[spm_pkg::WRITE_BIT];
         if (start_op) begin
            flash_op_o.page <= page;
            lock_wr_data_o <= store_data_i[5:2];
            op_lock_reg <= !ctrl_reg[spm_pkg::ERASE_BIT] &&
                           !ctrl_reg[spm_pkg::WRITE_BIT];
         end
         // R15: page ops block the concurrent section, halting-page ops
         // stop the core
         if (start_op && (ctrl_reg[spm_pkg::ERASE_BIT] ||
                          ctrl_reg[spm_pkg::WRITE_BIT])) begin
            rww_block_o <= 1'b1;
            cpu_halt_o <= in_halting;
         end else if (timer_done) begin
            rww_block_o <= 1'b0;
            cpu_halt_o <= 1'b0;
         end
      end
   end

   // Buffer fill; re-enable, core reset and operation end wipe the temporary buffer
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buf_load_o <= 1'b0;
         buf_word_o <= 6'h00;
         buf_data_o <= 16'h0000;
         buf_clear_o <= 1'b0;
      end else begin
         buf_load_o <= store_go && !start_op && !ctrl_reg[spm_pkg::REEN_BIT];
         buf_clear_o <= reen_go || sys_reset_i || timer_done;
         if (store_go) begin
            buf_word_o <= word;
            buf_data_o <= store_data_i;
         end
      end
   end

   // ****************************************
   // Load path
   // ****************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_flash_reg <= 1'b0;
         pend_fuse_reg <= 1'b0;
         byte_sel_reg <= 1'b0;
         fuse_data_reg <= 8'hFF;
         flash_rd_o <= 1'b0;
         flash_word_addr_o <= 14'h0000;
      end else begin
         // R3: outside the read window a load is a plain flash read
         pend_flash_reg <= load_req_i && !read_mode;
         flash_rd_o <= load_req_i && !read_mode;
         pend_fuse_reg <= fuse_load;
         if (load_req_i && !read_mode) begin
            // R14: bit 0 picks the byte of the word
            flash_word_addr_o <= word_addr;
            byte_sel_reg <= byte_sel;
         end
         if (fuse_load) begin
            // R1, R5, R6: pointer selects lock, low or high fuse byte
            if (pointer_i[14:0] == spm_pkg::PTR_LOCK) begin
               fuse_data_reg <= lock_rd;
            end else if (pointer_i[14:0] == spm_pkg::PTR_LOW_FUSE) begin
               fuse_data_reg <= low_fuse_rd;
            end else if (pointer_i[14:0] == spm_pkg::PTR_HIGH_FUSE) begin
               fuse_data_reg <= high_fuse_rd;
            end else begin
               fuse_data_reg <= 8'hFF;
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_valid_o <= 1'b0;
         load_data_o <= 8'h00;
      end else begin
         load_valid_o <= pend_flash_reg || pend_fuse_reg;
         if (pend_fuse_reg) begin
            load_data_o <= fuse_data_reg;
         end else if (pend_flash_reg) begin
            load_data_o <= byte_sel_reg ? flash_rdata_i[15:8] :
                           flash_rdata_i[7:0];
         end
      end
   end

   // ****************************************
   // Register port and boot start
   // ****************************************
   assign ctrl_view = {1'b0, busy_flag_reg, 1'b0, ctrl_reg[4:1],
                       state_reg != spm_pkg::ST_IDLE};

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
         boot_start_o <= spm_pkg::BOOT_START_2K;
      end else begin
         boot_start_o <= boot_start;
         if (reg_rd_i && reg_addr_i == spm_pkg::CTRL_ADDR) begin
            reg_rdata_o <= ctrl_view;
         end else if (reg_rd_i && reg_addr_i == spm_pkg::STAT_ADDR) begin
            reg_rdata_o <= {5'h00, op_lock_reg, cpu_halt_o, timer_busy};
         end else begin
            reg_rdata_o <= 8'h00;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   a_lock_readback: assert property ( // R1
      fuse_load && pointer_i[14:0] == spm_pkg::PTR_LOCK |->
      ##2 load_valid_o && load_data_o == {2'b11, ~$past(lock_prog_i, 2)})
      else $error("lock byte not returned");
   a_low_fuse: assert property ( // R5
      fuse_load && pointer_i[14:0] == spm_pkg::PTR_LOW_FUSE |->
      ##2 load_valid_o && load_data_o == ~$past(low_fuse_prog_i, 2))
      else $error("low fuse byte not returned");
   a_high_fuse: assert property ( // R6
      fuse_load && pointer_i[14:0] == spm_pkg::PTR_HIGH_FUSE |->
      ##2 load_valid_o && load_data_o == ~$past(high_fuse_prog_i, 2))
      else $error("high fuse byte not returned");
   a_window_expiry: assert property ( // R2
      ctrl_wr && reg_wdata_i[spm_pkg::EN_BIT] &&
      reg_wdata_i[spm_pkg::LOCK_BIT] |->
      ##[1:4] state_reg != spm_pkg::ST_ARMED)
      else $error("read window not closed");
   a_store_window: assert property ( // R18
      ctrl_wr && reg_wdata_i[spm_pkg::EN_BIT] &&
      !reg_wdata_i[spm_pkg::LOCK_BIT] ##1
      (!store_req_i && !sys_reset_i) [*3] |=>
      armed ##1 state_reg != spm_pkg::ST_ARMED)
      else $error("store window not four cycles");
   a_plain_read: assert property ( // R3
      load_req_i && !read_mode |->
      ##1 flash_rd_o && flash_word_addr_o == $past(pointer_i[14:1]))
      else $error("plain flash read missing");
   a_reset_keeps_op: assert property ( // R8
      state_reg == spm_pkg::ST_RUN && sys_reset_i && !timer_done |=>
      state_reg == spm_pkg::ST_RUN)
      else $error("core reset aborted operation");
   a_busy_holds: assert property ( // R16
      busy_flag_reg && !reen_go |=> busy_flag_reg)
      else $error("busy flag dropped without re-enable");
   a_halt_section: assert property ( // R15
      start_op && ctrl_reg[spm_pkg::ERASE_BIT] |=>
      rww_block_o && cpu_halt_o == $past(in_halting))
      else $error("fetch blocking wrong during operation");
endmodule // self_program_fuse_lock_readback

// ### hdl/spm_pkg.sv
// Constants and types shared by the self-programming support block.
// Assumes a single 25 MHz core clock.
package spm_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 25;
   localparam int PROG_MIN_US = 3700;
   localparam int PROG_MAX_US = 4500;
   // Aim at the middle so oscillator spread stays inside both limits
   localparam int PROG_US = (PROG_MIN_US + PROG_MAX_US) / 2;
   localparam int TICK_CYCLES = CLK_MHZ;
   localparam int PROG_TICKS = PROG_US;
   localparam logic [2:0] LOAD_WIN = 3'h3;
   localparam logic [2:0] STORE_WIN = 3'h4;
   // ****************************************
   // Register map and control fields
   // ****************************************
   localparam logic [5:0] CTRL_ADDR = 6'h00;
   localparam logic [5:0] STAT_ADDR = 6'h01;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int EN_BIT = 0;
   localparam int ERASE_BIT = 1;
   localparam int WRITE_BIT = 2;
   localparam int LOCK_BIT = 3;
   localparam int REEN_BIT = 4;
   localparam int BUSY_BIT = 6;
   // ****************************************
   // Pointer values and flash geometry
   // ****************************************
   localparam logic [14:0] PTR_LOW_FUSE = 15'h0000;
   localparam logic [14:0] PTR_LOCK = 15'h0001;
   localparam logic [14:0] PTR_HIGH_FUSE = 15'h0003;
   localparam logic [7:0] HALT_FIRST_PAGE = 8'hE0;
   localparam int BOOT_SZ_POS = 1;
   localparam logic [13:0] BOOT_START_256 = 14'h3F00;
   localparam logic [13:0] BOOT_START_512 = 14'h3E00;
   localparam logic [13:0] BOOT_START_1K = 14'h3C00;
   localparam logic [13:0] BOOT_START_2K = 14'h3800;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic erase;
      logic write;
      logic [7:0] page;
   } flash_op_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARMED = 3'b010,
      ST_RUN = 3'b100
   } seq_state_t;
endpackage

// ### tb/flash_model.sv
// Flash array model: answers word reads for the sequencer.
// Assumes reads are combinational and only valid while flash_rd_i is high.
module flash_model (
   // Read port
   input wire logic flash_rd_i,
   input wire logic [13:0] word_addr_i,
   output logic [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // word read data
   // Outside a read the array shows a changed pattern, not the last word
   assign rdata_o = flash_rd_i ? {2'b10, word_addr_i} :
                    {2'b01, ~word_addr_i};
endmodule // flash_model

// ### tb/tb_self_program_fuse_lock_readback.sv
// Testbench for the self-programming sequencer.
// Assumes the flash model above and short timer parameters (8 cycles).
module tb_self_program_fuse_lock_readback;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, rst_n_i, sys_reset_i, reg_wr_i, reg_rd_i, load_req_i;
   logic store_req_i, load_valid_o, lock_wr_o, flash_rd_o, buf_load_o;
   logic buf_clear_o, cpu_halt_o, rww_block_o, eeprom_write_busy_i;
   logic [5:0] reg_addr_i;
   logic [5:0] buf_word_o;
   logic [7:0] reg_wdata_i, reg_rdata_o, load_data_o;
   logic [15:0] pointer_i, store_data_i, flash_rdata_i, buf_data_o;
   logic [3:0] lock_wr_data_o;
   logic [13:0] flash_word_addr_o, boot_start_o;
   spm_pkg::flash_op_t flash_op_o;
   int fails, n_compared, cyc, n;
   logic [15:0] ptr [3] = '{16'h0001, 16'h0000, 16'h0003};
   logic [7:0] exp [3] = '{8'hEA, 8'hA5, 8'hFD};
   logic [15:0] eptr [2] = '{16'hF081, 16'h6F80};

   self_program_fuse_lock_readback #(.TICK_CYCLES(2), .PROG_TICKS(4))
   i_self_program_fuse_lock_readback (
      .clock_i, .rst_n_i, .sys_reset_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pointer_i, .load_req_i,
      .store_req_i, .store_data_i, .eeprom_write_busy_i,
      .load_valid_o, .load_data_o, .low_fuse_prog_i(8'h5A),
      .high_fuse_prog_i(8'h02), .lock_prog_i(6'h15), .lock_wr_o,
      .lock_wr_data_o, .flash_rd_o, .flash_word_addr_o, .flash_rdata_i,
      .flash_op_o, .buf_load_o, .buf_word_o, .buf_data_o, .buf_clear_o,
      .cpu_halt_o, .rww_block_o, .boot_start_o);

   flash_model i_flash_model (
      .flash_rd_i(flash_rd_o),
      .word_addr_i(flash_word_addr_o),
      .rdata_o(flash_rdata_i));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic test_done;
      $display("mismatches %0d, compares %0d", fails, n_compared);
      if (fails == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      n_compared++;
      if (got !== want) begin
         fails++;
         $display("BAD at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic rd(input logic [5:0] a);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
   endtask

   // Control write, then a load or store after gap idle cycles
   task automatic op(input logic [7:0] c, input logic [15:0] p,
                     input bit st, input int gap);
      @(posedge clock_i);
      reg_addr_i <= spm_pkg::CTRL_ADDR;
      reg_wdata_i <= c;
      reg_wr_i <= 1'b1;
      pointer_i <= p;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      repeat (gap) @(posedge clock_i);
      if (st) store_req_i <= 1'b1;
      else load_req_i <= 1'b1;
      @(posedge clock_i);
      load_req_i <= 1'b0;
      store_req_i <= 1'b0;
   endtask

   task automatic get_load(input logic [7:0] want);
      int k;
      k = 0;
      do begin
         @(posedge clock_i);
         #1 k++;
      end while (load_valid_o !== 1'b1 && k < 6);
      chk(load_valid_o, 1'b1);
      chk(load_data_o, want);
   endtask

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // A hang counts as a mismatch
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         test_done();
      end
   end

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      {rst_n_i, sys_reset_i, reg_wr_i, reg_rd_i, load_req_i} = '0;
      {store_req_i, eeprom_write_busy_i, fails, n_compared, cyc} = '0;
      reg_addr_i = '0;
      reg_wdata_i = '0;
      pointer_i = '0;
      store_data_i = 16'h00D7;
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      #1 chk(boot_start_o, 14'h3E00);
      for (int i = 0; i < 3; i++) begin
         op(8'h09, ptr[i], 1'b0, 0);
         get_load(exp[i]);
         rd(spm_pkg::CTRL_ADDR);
         chk(reg_rdata_o & 8'h09, 8'h00);
      end
      op(8'h09, 16'h0001, 1'b0, 3);
      get_load(8'h80);
      // Control write refused while the EEPROM is busy
      @(posedge clock_i) eeprom_write_busy_i <= 1'b1;
      op(8'h09, 16'h0001, 1'b0, 0);
      get_load(8'h80);
      @(posedge clock_i) eeprom_write_busy_i <= 1'b0;
      @(posedge clock_i);
      pointer_i <= 16'h8A57;
      load_req_i <= 1'b1;
      @(posedge clock_i);
      load_req_i <= 1'b0;
      #1 chk(flash_rd_o, 1'b1);
      chk(flash_word_addr_o, 14'h052B);
      get_load(8'h85);
      rd(spm_pkg::STAT_ADDR);
      chk(reg_rdata_o, 8'h00);
      op(8'h09, 16'h0001, 1'b1, 0);
      #1 chk(lock_wr_o, 1'b1);
      chk(lock_wr_data_o, 4'h5);
      rd(spm_pkg::STAT_ADDR);
      chk(reg_rdata_o, 8'h05);
      repeat (14) @(posedge clock_i);
      // Store after the four-cycle window is ignored
      op(8'h01, 16'h0000, 1'b1, 4);
      #1 chk(buf_load_o, 1'b0);
      op(8'h01, 16'h007E, 1'b1, 0);
      #1 chk(buf_load_o, 1'b1);
      chk(buf_word_o, 6'h3F);
      chk(buf_data_o, 16'h00D7);
      for (int i = 0; i < 2; i++) begin
         op(8'h03, eptr[i], 1'b1, 0);
         #1 chk(flash_op_o.erase, 1'b1);
         chk(flash_op_o.page, eptr[i][14:7]);
         chk(cpu_halt_o, i == 0);
         n = 0;
         while (rww_block_o === 1'b1 && n < 40) begin
            @(posedge clock_i);
            sys_reset_i <= (i == 0 && n == 2);
            #1 n++;
         end
         chk(n >= 8 && n <= 9, 1'b1);
         chk(buf_clear_o, 1'b1);
         rd(spm_pkg::CTRL_ADDR);
         chk(reg_rdata_o & 8'h41, 8'h40);
         op(8'h11, eptr[i], 1'b1, 0);
         repeat (2) @(posedge clock_i);
         rd(spm_pkg::CTRL_ADDR);
         chk(reg_rdata_o & 8'h40, 8'h00);
      end
      // Page write with the word field held at zero
      op(8'h05, 16'h6F80, 1'b1, 0);
      #1 chk(flash_op_o.write, 1'b1);
      chk(flash_op_o.erase, 1'b0);
      chk(rww_block_o, 1'b1);
      test_done();
   end
endmodule // tb_self_program_fuse_lock_readback
